// File: ssl_consts.svh
// register offsets, field positions, reset values and widths of the slave pin block
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH

// register offsets, byte addressed on the plain register port
`define SSL_OFF_OWN_ADDR      8'h09
`define SSL_OFF_MSG_LOW       8'h0a
`define SSL_OFF_MSG_HIGH      8'h0b
`define SSL_OFF_LINK_CTL      8'h0e
`define SSL_OFF_BUS_CTL       8'h0f

// field positions
`define SSL_ADDR_MSB          6
`define SSL_CLK_CTL_BIT       2
`define SSL_LINE1_BIT         1
`define SSL_LINE0_BIT         0
`define SSL_ADDR_FIELD        7:1
`define SSL_MSG_HI            15:8
`define SSL_MSG_LO            7:0

// reset values
`define SSL_OWN_ADDR_RST      7'h44
`define SSL_MSG_RST           16'h0000
`define SSL_CLK_CTL_RST       1'b1
`define SSL_RD_IDLE           8'h00

// serial framing
`define SSL_BITS_PER_BYTE     4'h8
`define SSL_BITCNT_RST        4'h0

`endif

// File: ssl_link_master.sv
// behavioural link master that frames writes and reads toward the slave
`timescale 1ns/10ps
`default_nettype none

module ssl_link_master (
    // link clock and data line level
    input  wire logic i_link_clk,
    input  wire logic i_sda,
    // open-drain enables, low pulls the line down
    output logic      o_scl_oe_n,
    output logic      o_sda_oe_n
);
    // released outside frames, so the pull-ups hold both lines high
    initial
    begin
        o_scl_oe_n = 1'h1;
        o_sda_oe_n = 1'h1;
    end

    // six link clocks a step, so clock high levels last six and low levels twelve, keeps the receiver's sampling well inside each level
    task automatic half();
        repeat (6) @(posedge i_link_clk);
    endtask

    task automatic start_cond();
        half();
        o_sda_oe_n <= 1'h0;
        half();
        o_scl_oe_n <= 1'h0;
    endtask

    // data moves only mid-low, never beside a clock edge, to avoid false start or stop
    task automatic byte_x(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--)
        begin
            half();
            o_sda_oe_n <= (i < 0) ? 1'h1 : b[i];
            half();
            o_scl_oe_n <= 1'h1;
            half();
            ack = ~i_sda;
            o_scl_oe_n <= 1'h0;
        end
    endtask

    // own address in bits 7:1, direction flag in bit 0
    task automatic send_addr(input logic [6:0] a, input logic rw, output logic ack);
        byte_x({a, rw}, ack);
    endtask

    task automatic stop_cond();
        half();
        o_sda_oe_n <= 1'h0;
        half();
        o_scl_oe_n <= 1'h1;
        half();
        o_sda_oe_n <= 1'h1;
        half();
    endtask
endmodule

`default_nettype wire

// File: ssl_pkg.sv
// types of the slave address, message and pin control block
package ssl_pkg;

    // link-side slave receiver states
    typedef enum logic [2:0] {
        SSL_IDLE   = 3'b000,
        SSL_ADDR   = 3'b001,
        SSL_AACK   = 3'b010,
        SSL_DATA   = 3'b011,
        SSL_DACK   = 3'b100,
        SSL_IGNORE = 3'b101
    } ssl_state_t;

    // state of the register-side (resume well) logic
    typedef struct packed {
        logic [6:0]  own_addr;
        logic        link_clk_ctl;
        logic        bus_clk_ctl;
        logic [15:0] msg;
        logic [1:0]  link0_s;
        logic [1:0]  link1_s;
        logic [1:0]  bclk_s;
        logic [1:0]  bdat_s;
        logic [1:0]  tog_s;
        logic        tog_d;
        logic [7:0]  rd_data;
        logic        link0_oe_n;
        logic        bclk_oe_n;
    } ssl_reg_t;

    // state of the link-clock logic
    typedef struct packed {
        logic [1:0]  rst_s;
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic        scl_d;
        logic        sda_d;
        logic [6:0]  addr_s0;
        logic [6:0]  addr_s1;
        ssl_state_t  state;
        logic [3:0]  bitcnt;
        logic [7:0]  shift;
        logic        rw;
        logic        byte_hi;
        logic [7:0]  lo_hold;
        logic [15:0] msg;
        logic        tog;
        logic        sda_oe_n;
    } ssl_link_t;

endpackage

// File: ssl_slave_pins.sv
// slave address, received message and pin control registers with the link-side receiver
`timescale 1ns/10ps
`default_nettype none
`include "ssl_consts.svh"

module ssl_slave_pins
    import ssl_pkg::*;
(
    // register clock and resume-well reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rd_data,
    // link clock, sampling the link lines
    input  wire logic       i_link_clk,
    // link line 0 (clock of the link) and link line 1 (data of the link)
    input  wire logic       i_link_line0,
    output logic            o_link_line0_oe_n,
    input  wire logic       i_link_line1,
    output logic            o_link_line1_oe_n,
    // bus clock and bus data lines
    input  wire logic       i_bus_clock_line,
    output logic            o_bus_clock_line_oe_n,
    input  wire logic       i_bus_data_line
);

    ssl_reg_t  r_r;
    ssl_reg_t  r_nxt;
    ssl_link_t l_r;
    ssl_link_t l_nxt;

    // reset image of the register side; the pci reset never reaches it
    localparam ssl_reg_t REG_RST = '{
        own_addr:     `SSL_OWN_ADDR_RST,
        link_clk_ctl: `SSL_CLK_CTL_RST,
        bus_clk_ctl:  `SSL_CLK_CTL_RST,
        msg:          `SSL_MSG_RST,
        link0_s:      2'h3,
        link1_s:      2'h3,
        bclk_s:       2'h3,
        bdat_s:       2'h3,
        tog_s:        2'h0,
        tog_d:        1'b0,
        rd_data:      `SSL_RD_IDLE,
        link0_oe_n:   1'b1,
        bclk_oe_n:    1'b1
    };

    // register side, clocked by i_clk in the resume well
    //
    // the only reset seen here is i_srst, the resume-well reset; there is
    // no pci reset input, so a pci bus reset cannot disturb the own
    // address, the captured message or the two clock force bits
    //
    // register map, byte addressed:
    //   own address   bits 6:0 read/write, bit 7 reads zero
    //   message low   read only, first data byte of the last pair
    //   message high  read only, second data byte of the last pair
    //   link control  bit 2 force bit, bits 1:0 link line levels
    //   bus control   bit 2 force bit, bits 1:0 data, clock levels
    //
    // writes land on the edge that takes the strobe; a read answers one
    // cycle later for that cycle only, then the port idles at zero
    //
    // reserved bits own no flops: they read zero and swallow writes with
    // no masking logic that could be got wrong later
    //
    // unmapped addresses are no error: writes vanish, reads give zero
    //
    // status bits pass two flops before the read mux, so a read shows
    // the pin as it stood about two clocks before the strobe; the
    // samplers run on through reset so status is right from the start
    //
    // the message comes over as a toggle plus a held word; the word moves
    // only with the toggle, which is seen here two clocks late, so the
    // word is still when copied and its bytes share one message
    //
    // the force bits reach the open-drain enables through one more flop,
    // so the pins come from a register, two clocks after the strobe
    //
    // the force bits are plain storage; nothing else in this block ever
    // drives the bus clock line or link line 0
    //
    // a pair arriving within about four clocks of the last can be lost;
    // the link is far slower than that, so it is not guarded against
    //
    // register side: decode, pin sampling, message capture
    always_comb
    begin
        r_nxt = r_r;
        // two-flop sampling of the live pin levels
        r_nxt.link0_s = {r_r.link0_s[0], i_link_line0};
        r_nxt.link1_s = {r_r.link1_s[0], i_link_line1};
        r_nxt.bclk_s  = {r_r.bclk_s[0], i_bus_clock_line};
        r_nxt.bdat_s  = {r_r.bdat_s[0], i_bus_data_line};
        // message event crosses as a toggle; data held still in the link domain
        r_nxt.tog_s   = {r_r.tog_s[0], l_r.tog};
        r_nxt.tog_d   = r_r.tog_s[1];
        if (r_r.tog_s[1] != r_r.tog_d)
        begin
            r_nxt.msg = l_r.msg;
        end
        // software writes; reserved bits simply have no storage
        if (i_wr)
        begin
            case (i_addr)
                `SSL_OFF_OWN_ADDR: r_nxt.own_addr = i_wr_data[`SSL_ADDR_MSB:0];
                `SSL_OFF_LINK_CTL: r_nxt.link_clk_ctl = i_wr_data[`SSL_CLK_CTL_BIT];
                `SSL_OFF_BUS_CTL:  r_nxt.bus_clk_ctl = i_wr_data[`SSL_CLK_CTL_BIT];
                default:           r_nxt.own_addr = r_r.own_addr;
            endcase
        end
        // read data stands only in the cycle after the strobe
        r_nxt.rd_data = `SSL_RD_IDLE;
        if (i_rd)
        begin
            case (i_addr)
                `SSL_OFF_OWN_ADDR: r_nxt.rd_data = {1'b0, r_r.own_addr};
                `SSL_OFF_MSG_LOW:  r_nxt.rd_data = r_r.msg[`SSL_MSG_LO];
                `SSL_OFF_MSG_HIGH: r_nxt.rd_data = r_r.msg[`SSL_MSG_HI];
                `SSL_OFF_LINK_CTL:
                begin
                    r_nxt.rd_data = `SSL_RD_IDLE;
                    r_nxt.rd_data[`SSL_CLK_CTL_BIT] = r_r.link_clk_ctl;
                    r_nxt.rd_data[`SSL_LINE1_BIT] = r_r.link1_s[1];
                    r_nxt.rd_data[`SSL_LINE0_BIT] = r_r.link0_s[1];
                end
                `SSL_OFF_BUS_CTL:
                begin
                    r_nxt.rd_data = `SSL_RD_IDLE;
                    r_nxt.rd_data[`SSL_CLK_CTL_BIT] = r_r.bus_clk_ctl;
                    r_nxt.rd_data[`SSL_LINE1_BIT] = r_r.bdat_s[1];
                    r_nxt.rd_data[`SSL_LINE0_BIT] = r_r.bclk_s[1];
                end
                default:           r_nxt.rd_data = `SSL_RD_IDLE;
            endcase
        end
        // clock forcing overrides any other driver of the line
        r_nxt.link0_oe_n = r_r.link_clk_ctl;
        r_nxt.bclk_oe_n  = r_r.bus_clk_ctl;
    end

    // register side flops; only the resume-well reset clears them
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            r_r <= REG_RST;
            // samplers keep running so status follows the pins through reset
            r_r.link0_s <= r_nxt.link0_s;
            r_r.link1_s <= r_nxt.link1_s;
            r_r.bclk_s  <= r_nxt.bclk_s;
            r_r.bdat_s  <= r_nxt.bdat_s;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // link side, clocked by i_link_clk
    //
    // line 0 is the clock wire of the link and line 1 its data wire; both
    // are open drain and pass two flops before any logic reads them, so
    // each level of the clock wire must last at least four link clocks
    //
    // a frame is start, address byte, data byte pairs, stop; the address
    // byte holds the own address in bits 7:1 and the direction in bit 0
    //
    // a matching write is acknowledged, then every data byte is; the
    // first byte of a pair is parked, the second completes it, and the
    // pair is published as one word with a flip of the event toggle
    //
    // a matching read is acknowledged and then left alone, so the far
    // master reads released, all-ones data until it stops
    //
    // a wrong address is ignored until the next start; a stop returns to
    // idle from any state, and a lone trailing byte is dropped
    //
    // the acknowledge starts at the clock fall that ends the eighth bit,
    // seen about three link clocks late, and ends at the next fall
    //
    // the receiver only listens and acknowledges; it never stretches
    // the clock wire, so a slow register side cannot stall a frame
    //
    // the own address crosses as quasi-static bits through two flops;
    // change it only while the link is idle, or a frame in flight may
    // compare against a half-updated address
    //
    // reset crosses through its own two-flop sampler, so i_srst must
    // stand for at least three link clocks for this side to see it
    //
    // link-side edge and condition detection
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl      = l_r.scl_s[1];
    assign sda      = l_r.sda_s[1];
    assign scl_rise = scl & ~l_r.scl_d;
    assign scl_fall = ~scl & l_r.scl_d;
    assign start_c  = scl & l_r.scl_d & l_r.sda_d & ~sda;
    assign stop_c   = scl & l_r.scl_d & ~l_r.sda_d & sda;

    // link side: receive address byte then message bytes low, high
    always_comb
    begin
        l_nxt = l_r;
        l_nxt.rst_s   = {l_r.rst_s[0], i_srst};
        l_nxt.scl_s   = {l_r.scl_s[0], i_link_line0};
        l_nxt.sda_s   = {l_r.sda_s[0], i_link_line1};
        l_nxt.scl_d   = scl;
        l_nxt.sda_d   = sda;
        // own address is quasi-static; software must not rewrite it mid-frame
        l_nxt.addr_s0 = r_r.own_addr;
        l_nxt.addr_s1 = l_r.addr_s0;
        if (start_c)
        begin
            // start or repeated start restarts address reception
            l_nxt.state    = SSL_ADDR;
            l_nxt.bitcnt   = `SSL_BITCNT_RST;
            l_nxt.sda_oe_n = 1'b1;
        end
        else if (stop_c)
        begin
            l_nxt.state    = SSL_IDLE;
            l_nxt.sda_oe_n = 1'b1;
        end
        else
        begin
            case (l_r.state)
                // waits for a start condition
                SSL_IDLE:
                begin
                    l_nxt.sda_oe_n = 1'b1;
                end
                // shifts in the address and the direction flag
                SSL_ADDR:
                begin
                    if (scl_rise)
                    begin
                        l_nxt.shift  = {l_r.shift[6:0], sda};
                        l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                    end
                    else if (scl_fall && l_r.bitcnt == `SSL_BITS_PER_BYTE)
                    begin
                        // address sits above the direction bit
                        if (l_r.shift[`SSL_ADDR_FIELD] == l_r.addr_s1)
                        begin
                            l_nxt.sda_oe_n = 1'b0;
                            l_nxt.rw       = l_r.shift[0];
                            l_nxt.state    = SSL_AACK;
                        end
                        else
                        begin
                            l_nxt.state = SSL_IGNORE;
                        end
                    end
                end
                // holds the address acknowledge for one bit
                SSL_AACK:
                begin
                    if (scl_fall)
                    begin
                        l_nxt.sda_oe_n = 1'b1;
                        l_nxt.bitcnt   = `SSL_BITCNT_RST;
                        l_nxt.byte_hi  = 1'b0;
                        // reads are acknowledged but return released (all ones) data
                        l_nxt.state    = l_r.rw ? SSL_IGNORE : SSL_DATA;
                    end
                end
                // shifts in a data byte, then acknowledges it
                SSL_DATA:
                begin
                    if (scl_rise)
                    begin
                        l_nxt.shift  = {l_r.shift[6:0], sda};
                        l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                    end
                    else if (scl_fall && l_r.bitcnt == `SSL_BITS_PER_BYTE)
                    begin
                        l_nxt.sda_oe_n = 1'b0;
                        l_nxt.state    = SSL_DACK;
                        if (l_r.byte_hi)
                        begin
                            // whole message published at once, signalled by the toggle flip in the same cycle
                            l_nxt.msg = {l_r.shift, l_r.lo_hold};
                            l_nxt.tog = ~l_r.tog;
                        end
                        else
                        begin
                            l_nxt.lo_hold = l_r.shift;
                        end
                    end
                end
                // releases the line after the data acknowledge
                SSL_DACK:
                begin
                    if (scl_fall)
                    begin
                        l_nxt.sda_oe_n = 1'b1;
                        l_nxt.bitcnt   = `SSL_BITCNT_RST;
                        l_nxt.byte_hi  = ~l_r.byte_hi;
                        l_nxt.state    = SSL_DATA;
                    end
                end
                // not ours: stays off the line until a start
                SSL_IGNORE:
                begin
                    l_nxt.sda_oe_n = 1'b1;
                end
                default:
                begin
                    l_nxt.state    = SSL_IDLE;
                    l_nxt.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // link flops; reset arrives through its own two-flop sampler
    always_ff @(posedge i_link_clk)
    begin
        if (l_r.rst_s[1])
        begin
            l_r          <= l_nxt;
            l_r.state    <= SSL_IDLE;
            l_r.bitcnt   <= `SSL_BITCNT_RST;
            l_r.shift    <= `SSL_RD_IDLE;
            l_r.rw       <= 1'b0;
            l_r.byte_hi  <= 1'b0;
            l_r.lo_hold  <= `SSL_RD_IDLE;
            l_r.sda_oe_n <= 1'b1;
            // word and toggle cleared too, so no unknown word ever crosses
            l_r.tog      <= 1'b0;
            l_r.msg      <= `SSL_MSG_RST;
        end
        else
        begin
            l_r <= l_nxt;
        end
    end

    // outputs straight from flops
    // line 1 enable is a link-domain flop, the other three register-domain
    assign o_rd_data             = r_r.rd_data;
    assign o_link_line0_oe_n     = r_r.link0_oe_n;
    assign o_bus_clock_line_oe_n = r_r.bclk_oe_n;
    assign o_link_line1_oe_n     = l_r.sda_oe_n;

endmodule
`default_nettype wire

// File: ssl_slave_pins_monitor.sv
// concurrent checks on the ports of the slave pin block
`timescale 1ns/10ps
`default_nettype none

module ssl_slave_pins_monitor (
    // register side
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rd_data,
    // link side
    input wire logic       i_link_clk,
    input wire logic       i_link_line0,
    input wire logic       o_link_line0_oe_n,
    input wire logic       i_link_line1,
    input wire logic       o_link_line1_oe_n,
    // bus pins
    input wire logic       i_bus_clock_line,
    input wire logic       o_bus_clock_line_oe_n,
    input wire logic       i_bus_data_line
);
    addr_bit7_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(i_rd) && $past(i_addr) == 8'h09 |-> !o_rd_data[7]) else $error("addr bit7 set");
    ctl_resv_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(i_rd) && $past(i_addr[7:1]) == 7'h07 |-> o_rd_data[7:3] == 5'h00)
        else $error("reserved ctl bits set");
    // a second write to the same place would legally override, so it is excluded
    link_force_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr && i_addr == 8'h0e && !i_wr_data[2] ##1 !(i_wr && i_addr == 8'h0e)
        |-> ##1 !o_link_line0_oe_n) else $error("link line0 not forced");
    link_free_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr && i_addr == 8'h0e && i_wr_data[2] ##1 !(i_wr && i_addr == 8'h0e)
        |-> ##1 o_link_line0_oe_n) else $error("link line0 not released");
    bus_force_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr && i_addr == 8'h0f && !i_wr_data[2] ##1 !(i_wr && i_addr == 8'h0f)
        |-> ##1 !o_bus_clock_line_oe_n) else $error("bus clock not forced");
    bus_free_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr && i_addr == 8'h0f && i_wr_data[2] ##1 !(i_wr && i_addr == 8'h0f)
        |-> ##1 o_bus_clock_line_oe_n) else $error("bus clock not released");
    link_stat_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(i_rd) && $past(i_addr) == 8'h0e
        |-> o_rd_data[1:0] == {$past(i_link_line1, 3), $past(i_link_line0, 3)})
        else $error("link status wrong");
    bus_stat_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(i_rd) && $past(i_addr) == 8'h0f
        |-> o_rd_data[1:0] == {$past(i_bus_data_line, 3), $past(i_bus_clock_line, 3)})
        else $error("bus status wrong");
    ack_len_a: assert property (@(posedge i_link_clk) disable iff (i_srst)
        $fell(o_link_line1_oe_n) |-> ##[4:60] o_link_line1_oe_n) else $error("ack too long");
endmodule

bind ssl_slave_pins ssl_slave_pins_monitor u_ssl_slave_pins_monitor (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
    .i_rd(i_rd), .o_rd_data(o_rd_data), .i_link_clk(i_link_clk),
    .i_link_line0(i_link_line0), .o_link_line0_oe_n(o_link_line0_oe_n),
    .i_link_line1(i_link_line1), .o_link_line1_oe_n(o_link_line1_oe_n),
    .i_bus_clock_line(i_bus_clock_line), .o_bus_clock_line_oe_n(o_bus_clock_line_oe_n),
    .i_bus_data_line(i_bus_data_line)
);

`default_nettype wire

// File: tb.sv
// self-checking bench for the slave address, message and pin control block
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic       i_clk = 1'h0;
    logic       i_link_clk = 1'h0;
    logic       i_srst = 1'h1;
    logic       i_wr = 1'h0;
    logic       i_rd = 1'h0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wr_data = 8'h00;
    logic       bus_clk_ext = 1'h1;
    logic       bus_dat_ext = 1'h1;
    logic [7:0] o_rd_data;
    logic       o_link_line0_oe_n;
    logic       o_link_line1_oe_n;
    logic       o_bus_clock_line_oe_n;
    logic       m_scl_oe_n;
    logic       m_sda_oe_n;
    logic       ack;
    int         fails = 0;
    int         total_checks = 0;
    // open-drain lines with pull-ups: any party pulling low wins
    wire        link0 = o_link_line0_oe_n & m_scl_oe_n;
    wire        link1 = o_link_line1_oe_n & m_sda_oe_n;
    wire        bus_clk = o_bus_clock_line_oe_n & bus_clk_ext;

    // register clock, and a link clock offset so the two edges never coincide
    always #25 i_clk = ~i_clk;
    initial
    begin
        #7;
        forever #15 i_link_clk = ~i_link_clk;
    end

    ssl_slave_pins u_ssl_slave_pins (
        .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_link_clk(i_link_clk),
        .i_link_line0(link0), .o_link_line0_oe_n(o_link_line0_oe_n),
        .i_link_line1(link1), .o_link_line1_oe_n(o_link_line1_oe_n),
        .i_bus_clock_line(bus_clk), .o_bus_clock_line_oe_n(o_bus_clock_line_oe_n),
        .i_bus_data_line(bus_dat_ext)
    );

    ssl_link_master u_ssl_link_master (
        .i_link_clk(i_link_clk), .i_sda(link1), .o_scl_oe_n(m_scl_oe_n),
        .o_sda_oe_n(m_sda_oe_n)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
        total_checks++;
        if (got !== ex)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk1(input string nm, input logic ex, input logic got);
        total_checks++;
        if (got !== ex)
        begin
            fails++;
            $display("Error %s expected %b seen %b", nm, ex, got);
        end
    endtask

    // each access opens on a fresh edge, so strobes never change twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] ex, input string nm);
        @(posedge i_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1 chk8(nm, ex, o_rd_data);
    endtask

    task automatic frame(input logic [6:0] a, input logic [7:0] lo, input logic [7:0] hi,
                         input logic ex);
        u_ssl_link_master.start_cond();
        u_ssl_link_master.send_addr(a, 1'h0, ack);
        chk1("addr ack", ex, ack);
        u_ssl_link_master.byte_x(lo, ack);
        chk1("low ack", ex, ack);
        u_ssl_link_master.byte_x(hi, ack);
        chk1("high ack", ex, ack);
        u_ssl_link_master.stop_cond();
    endtask

    // hang guard
    initial
    begin
        repeat (100000) @(posedge i_clk);
        fails++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_srst <= 1'h0;
        repeat (4) @(posedge i_link_clk);
        rd_reg(8'h09, 8'h44, "own addr");
        rd_reg(8'h0a, 8'h00, "msg low");
        rd_reg(8'h0b, 8'h00, "msg high");
        rd_reg(8'h0e, 8'h07, "link ctl");
        rd_reg(8'h0f, 8'h07, "bus ctl");
        rd_reg(8'h20, 8'h00, "unmapped");
        frame(7'h44, 8'h34, 8'h12, 1'h1);
        wr_reg(8'h0a, 8'hff);
        rd_reg(8'h0a, 8'h34, "msg low");
        rd_reg(8'h0b, 8'h12, "msg high");
        frame(7'h48, 8'h55, 8'h66, 1'h0);
        rd_reg(8'h0b, 8'h12, "msg kept");
        wr_reg(8'h09, 8'haa);
        rd_reg(8'h09, 8'h2a, "own addr");
        frame(7'h2a, 8'hcd, 8'hab, 1'h1);
        rd_reg(8'h0a, 8'hcd, "msg low");
        rd_reg(8'h0b, 8'hab, "msg high");
        u_ssl_link_master.start_cond();
        u_ssl_link_master.send_addr(7'h2a, 1'h1, ack);
        chk1("read ack", 1'h1, ack);
        u_ssl_link_master.stop_cond();
        wr_reg(8'h0e, 8'hf8);
        repeat (4) @(posedge i_clk);
        chk1("link0 oe_n", 1'h0, o_link_line0_oe_n);
        rd_reg(8'h0e, 8'h02, "link ctl");
        wr_reg(8'h0e, 8'h04);
        repeat (4) @(posedge i_clk);
        rd_reg(8'h0e, 8'h07, "link ctl");
        bus_dat_ext <= 1'h0;
        wr_reg(8'h0f, 8'h00);
        repeat (4) @(posedge i_clk);
        chk1("bus clk oe_n", 1'h0, o_bus_clock_line_oe_n);
        rd_reg(8'h0f, 8'h00, "bus ctl");
        bus_dat_ext <= 1'h1;
        bus_clk_ext <= 1'h0;
        wr_reg(8'h0f, 8'h04);
        repeat (4) @(posedge i_clk);
        rd_reg(8'h0f, 8'h06, "bus ctl");
        bus_clk_ext <= 1'h1;
        // force both clock bits low so the reset below has something to undo
        wr_reg(8'h0e, 8'h00);
        wr_reg(8'h0f, 8'h00);
        @(posedge i_clk);
        i_srst <= 1'h1;
        repeat (4) @(posedge i_clk);
        i_srst <= 1'h0;
        rd_reg(8'h09, 8'h44, "own addr");
        rd_reg(8'h0a, 8'h00, "msg low");
        rd_reg(8'h0b, 8'h00, "msg high");
        rd_reg(8'h0e, 8'h07, "link ctl");
        rd_reg(8'h0f, 8'h07, "bus ctl");
        stop_test();
    end
endmodule

`default_nettype wire
